/* File: dv/rsse_asserts.sv */
`timescale 1ns/1ps
// =====================================================================
// port checker for the rotate, subtract and skip slice
module rsse_asserts
    import rsse_pkg::*;
(
    // clock, enable, reset
    input wire logic core_clk_i,
    input wire logic clk_en_i,
    input wire logic rst_i,
    // issue and preset
    input wire logic issue_valid_i,
    input wire req_t issue_req_i,
    input wire logic issue_ready_o,
    input wire logic preset_i,
    input wire logic [7:0] preset_acc_i,
    input wire flags_t preset_flags_i,
    // results
    input wire logic mem_we_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] acc_o,
    input wire flags_t flags_o,
    input wire logic discard_o,
    input wire logic done_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic tk; // instruction taken at this edge
    op_t op; // operation on the issue port
    logic [7:0] m_q; // operand one edge back
    logic [2:0] sel_q; // bit select one edge back
    flags_t f_q; // flags one edge back
    logic [7:0] a_q; // accumulator one edge back
    logic [8:0] sum; // expected subtract sum, from saved copies
    assign tk = clk_en_i & issue_valid_i & issue_ready_o;
    assign op = issue_req_i.op;
    assign sum = {1'h0, a_q} + {1'h0, ~m_q} + {8'h00, f_q.carry_flag};
    // copies kept every edge so results can be tied to their cause
    always_ff @(posedge core_clk_i) begin
        m_q <= issue_req_i.mem_byte;
        sel_q <= issue_req_i.bit_sel;
        f_q <= flags_o;
        a_q <= acc_o;
    end
    property p_rot_lc_mem;
        tk && op == rotate_left_via_carry_mem |=> mem_we_o
            && mem_wdata_o == {m_q[6:0], f_q.carry_flag} && flags_o == {f_q[3:1], m_q[7]};
    endproperty
    a_rot_lc_mem: assert property (p_rot_lc_mem) else $error("left rotate to memory wrong");
    property p_rot_lc_acc;
        tk && op == rotate_left_via_carry_to_acc |=> !mem_we_o
            && acc_o == {m_q[6:0], f_q.carry_flag} && flags_o.carry_flag == m_q[7];
    endproperty
    a_rot_lc_acc: assert property (p_rot_lc_acc) else $error("left rotate to acc wrong");
    property p_rot_r_mem;
        tk && op == rotate_right_mem |=> mem_we_o
            && mem_wdata_o == {m_q[0], m_q[7:1]} && flags_o == f_q;
    endproperty
    a_rot_r_mem: assert property (p_rot_r_mem) else $error("right rotate to memory wrong");
    property p_rot_rc_acc;
        tk && op == rotate_right_via_carry_to_acc |=> !mem_we_o
            && acc_o == {f_q.carry_flag, m_q[7:1]} && flags_o.carry_flag == m_q[0];
    endproperty
    a_rot_rc_acc: assert property (p_rot_rc_acc) else $error("carry right rotate wrong");
    property p_sub_acc;
        tk && op == subtract_borrow_to_acc |=> acc_o == sum[7:0]
            && flags_o.carry_flag == sum[8] && flags_o.zero_flag == (sum[7:0] == 8'h00);
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract sum wrong");
    property p_set;
        tk && op == set_byte_mem |=> mem_we_o && mem_wdata_o == 8'hFF && flags_o == f_q && done_o;
    endproperty
    a_set: assert property (p_set) else $error("byte set wrong");
    property p_bit;
        tk && op == set_bit_mem |=> mem_we_o && mem_wdata_o == (m_q | (8'h01 << sel_q));
    endproperty
    a_bit: assert property (p_bit) else $error("bit set wrong");
    property p_dec;
        tk && op == dec_skip_zero_mem |=> mem_we_o && mem_wdata_o == m_q - 8'h01 && flags_o == f_q;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_skip;
        tk && op == inc_skip_zero_mem && issue_req_i.mem_byte == 8'hFF
            |=> discard_o && !issue_ready_o && !done_o ##1 done_o && !discard_o;
    endproperty
    a_skip: assert property (p_skip) else $error("skip timing wrong");
    property p_btst;
        tk && op == skip_if_bit_set && !issue_req_i.mem_byte[issue_req_i.bit_sel]
            |=> done_o && !discard_o && !mem_we_o;
    endproperty
    a_btst: assert property (p_btst) else $error("bit test skipped wrongly");
    c_sub_mem: cover property (tk && op == subtract_borrow_to_mem);
    c_disc: cover property (discard_o ##1 done_o);
    c_btst: cover property (tk && op == skip_if_bit_set ##1 discard_o);
endmodule
bind rotate_subtract_skip_exec rsse_asserts i_chk (.core_clk_i, .clk_en_i, .rst_i,
    .issue_valid_i, .issue_req_i, .issue_ready_o, .preset_i, .preset_acc_i, .preset_flags_i,
    .mem_we_o, .mem_wdata_o, .acc_o, .flags_o, .discard_o, .done_o);

/* File: dv/tb_rotate_subtract_skip_exec.sv */
`timescale 1ns/1ps
// =====================================================================
// self-checking bench for the execution slice
module tb_rotate_subtract_skip_exec;
    import rsse_pkg::*;
    logic core_clk_i = 1'h0, rst_i = 1'h1, issue_valid_i = 1'h0, preset_i = 1'h0;
    logic clk_en_i = 1'h1; // freeze control, low only in the freeze test
    req_t issue_req_i = '0; // instruction driven at falling edges
    logic [7:0] preset_acc_i = 8'h00;
    flags_t preset_flags_i = '0;
    logic issue_ready_o, mem_we_o, discard_o, done_o; // dut outputs
    logic [7:0] mem_wdata_o, acc_o;
    flags_t flags_o;
    logic we_s; // captured at the falling edge after the take
    logic [7:0] wd_s, acc_s, acc0;
    flags_t fl_s;
    int ncyc, n_fail = 0, comparisons = 0, cycles = 0;
    // enable stays high except in the freeze test
    rotate_subtract_skip_exec i_dut (.core_clk_i, .clk_en_i, .rst_i, .issue_valid_i,
        .issue_req_i, .issue_ready_o, .preset_i, .preset_acc_i, .preset_flags_i, .mem_we_o,
        .mem_wdata_o, .acc_o, .flags_o, .discard_o, .done_o);
    // =================================================================
    // clock and hang guard
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    // =================================================================
    // shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one issue; cycles counted from the take to done
    task automatic go(input op_t op, input logic [2:0] sel, input logic [7:0] m);
        @(negedge core_clk_i);
        acc0 = acc_o;
        issue_valid_i = 1'h1;
        issue_req_i = '{op, sel, m};
        @(negedge core_clk_i);
        issue_valid_i = 1'h0;
        {we_s, wd_s, acc_s, fl_s} = {mem_we_o, mem_wdata_o, acc_o, flags_o};
        ncyc = 0;
        if (done_o === 1'h1 && discard_o === 1'h0) ncyc = 1;
        else if (discard_o === 1'h1) begin
            @(negedge core_clk_i);
            if (done_o === 1'h1) ncyc = 2;
        end
    endtask
    task automatic ex(input op_t op, input logic [2:0] sel, input logic [7:0] m,
            input logic mem, input logic [7:0] res, input flags_t fl, input int cyc);
        go(op, sel, m);
        chk("mem_we", {7'h00, mem}, {7'h00, we_s});
        if (mem) begin
            chk("mem_wdata", res, wd_s);
            chk("acc kept", acc0, acc_s);
        end else chk("acc", res, acc_s);
        chk("flags", {4'h0, fl}, {4'h0, fl_s});
        chk("cycles", cyc[7:0], ncyc[7:0]);
    endtask
    task automatic preset(input logic [7:0] a, input flags_t f);
        @(negedge core_clk_i);
        {preset_i, preset_acc_i, preset_flags_i} = {1'h1, a, f};
        @(negedge core_clk_i);
        preset_i = 1'h0;
        chk("preset acc", a, acc_o);
    endtask
    // =================================================================
    // scenarios
    task automatic t_rotate();
        preset(8'h55, 4'hB);
        ex(rotate_left_via_carry_mem, 3'h0, 8'h81, 1'h1, 8'h03, 4'hB, 1);
        ex(rotate_left_via_carry_to_acc, 3'h0, 8'h40, 1'h0, 8'h81, 4'hA, 1);
        ex(rotate_right_mem, 3'h0, 8'h01, 1'h1, 8'h80, 4'hA, 1);
        ex(rotate_right_to_acc, 3'h0, 8'h02, 1'h0, 8'h01, 4'hA, 1);
        ex(rotate_right_via_carry_mem, 3'h0, 8'h01, 1'h1, 8'h00, 4'hB, 1);
        ex(rotate_right_via_carry_to_acc, 3'h0, 8'h00, 1'h0, 8'h80, 4'hA, 1);
        $display("test rotate done");
    endtask
    task automatic t_subtract();
        preset(8'h50, 4'h1);
        ex(subtract_borrow_to_acc, 3'h0, 8'h30, 1'h0, 8'h20, 4'h3, 1);
        ex(subtract_borrow_to_mem, 3'h0, 8'h20, 1'h1, 8'h00, 4'h7, 1);
        preset(8'h80, 4'h1);
        ex(subtract_borrow_to_acc, 3'h0, 8'h01, 1'h0, 8'h7F, 4'h9, 1);
        preset(8'h00, 4'h0);
        ex(subtract_borrow_to_mem, 3'h0, 8'h00, 1'h1, 8'hFF, 4'h0, 1);
        $display("test subtract done");
    endtask
    task automatic t_step();
        preset(8'h33, 4'hA);
        ex(dec_skip_zero_mem, 3'h0, 8'h01, 1'h1, 8'h00, 4'hA, 2);
        ex(dec_skip_zero_mem, 3'h0, 8'h00, 1'h1, 8'hFF, 4'hA, 1);
        ex(dec_skip_zero_to_acc, 3'h0, 8'h01, 1'h0, 8'h00, 4'hA, 2);
        ex(dec_skip_zero_to_acc, 3'h0, 8'h05, 1'h0, 8'h04, 4'hA, 1);
        ex(inc_skip_zero_mem, 3'h0, 8'hFF, 1'h1, 8'h00, 4'hA, 2);
        ex(inc_skip_zero_mem, 3'h0, 8'h7F, 1'h1, 8'h80, 4'hA, 1);
        ex(inc_skip_zero_to_acc, 3'h0, 8'hFF, 1'h0, 8'h00, 4'hA, 2);
        ex(inc_skip_zero_to_acc, 3'h0, 8'h00, 1'h0, 8'h01, 4'hA, 1);
        $display("test step done");
    endtask
    task automatic t_bits();
        preset(8'h66, 4'h5);
        ex(set_byte_mem, 3'h0, 8'h12, 1'h1, 8'hFF, 4'h5, 1);
        for (int i = 0; i < 8; i++) begin
            ex(set_bit_mem, i[2:0], 8'h5A, 1'h1, 8'h5A | (8'h01 << i), 4'h5, 1);
            ex(skip_if_bit_set, i[2:0], 8'h01 << i, 1'h0, 8'h66, 4'h5, 2);
            ex(skip_if_bit_set, i[2:0], ~(8'h01 << i), 1'h0, 8'h66, 4'h5, 1);
        end
        $display("test bits done");
    endtask
    // a request held through the dummy cycle must be ignored
    task automatic t_refuse();
        @(negedge core_clk_i);
        issue_valid_i = 1'h1;
        issue_req_i = '{inc_skip_zero_mem, 3'h0, 8'hFF};
        @(negedge core_clk_i);
        issue_req_i = '{set_byte_mem, 3'h0, 8'h12};
        chk("ready in dummy", 8'h00, {7'h00, issue_ready_o});
        @(negedge core_clk_i);
        issue_valid_i = 1'h0;
        chk("mem_we after dummy", 8'h00, {7'h00, mem_we_o});
        chk("done after dummy", 8'h01, {7'h00, done_o});
        $display("test refuse done");
    endtask
    // a low enable must freeze issue and preset; then a mid-run reset
    task automatic t_freeze();
        preset(8'h3C, 4'hF);
        @(negedge core_clk_i);
        clk_en_i = 1'h0;
        issue_valid_i = 1'h1;
        issue_req_i = '{set_byte_mem, 3'h0, 8'h12};
        preset_i = 1'h1;
        preset_acc_i = 8'hC3;
        repeat (2) @(negedge core_clk_i);
        chk("frozen mem_we", 8'h00, {7'h00, mem_we_o});
        chk("frozen acc", 8'h3C, acc_o);
        chk("frozen flags", 8'h0F, {4'h0, flags_o});
        clk_en_i = 1'h1;
        issue_valid_i = 1'h0;
        preset_i = 1'h0;
        rst_i = 1'h1;
        @(negedge core_clk_i);
        rst_i = 1'h0;
        chk("reset acc", 8'h00, acc_o);
        chk("reset flags", 8'h00, {4'h0, flags_o});
        chk("reset ready", 8'h01, {7'h00, issue_ready_o});
        // carry is clear after reset, so the top bit comes in as zero
        ex(rotate_right_via_carry_to_acc, 3'h0, 8'h01, 1'h0, 8'h00, 4'h1, 1);
        $display("test freeze done");
    endtask
    // =================================================================
    // main sequence
    initial begin
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'h0;
        chk("reset acc", 8'h00, acc_o);
        chk("reset ready", 8'h01, {7'h00, issue_ready_o});
        t_rotate();
        t_subtract();
        t_step();
        t_bits();
        t_refuse();
        t_freeze();
        wrap_up();
    end
endmodule

/* File: verilog/rotate_subtract_skip_exec.sv */
// Notes on behaviour
// - memory left rotate through carry, carry only
// - same rotate into accumulator, memory kept
// - memory right rotate, bit0 to bit7
// - right rotate into accumulator, no flags
// - memory right rotate through carry
// - right rotate through carry into accumulator
// - acc plus inverted byte plus carry
// - same sum written back to memory
// - decrement memory, skip when result zero
// - decrement into accumulator, skip on zero
// - whole byte set to all ones
// - set only selected bit to one
// - increment memory, skip on wrap zero
// - increment into accumulator, skip on zero
// - skip when selected bit is one
// - skip discards prefetch, adds dummy cycle
`timescale 1ns/1ps
module rotate_subtract_skip_exec
    import rsse_pkg::*;
(
    // clock, enable, reset
    input wire logic core_clk_i,
    input wire logic clk_en_i,
    input wire logic rst_i,
    // instruction issue
    input wire logic issue_valid_i,
    input wire req_t issue_req_i,
    output logic issue_ready_o,
    // accumulator and flag preset
    input wire logic preset_i,
    input wire logic [7:0] preset_acc_i,
    input wire flags_t preset_flags_i,
    // data memory write back
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    // core state
    output logic [7:0] acc_o,
    output flags_t flags_o,
    // sequencing
    output logic discard_o,
    output logic done_o
);

    // =================================================================
    // sequencer states
    typedef enum logic {
        st_run,                                   // ready for an issue
        st_dummy                                  // skip dummy cycle
    } seq_state_t;

    // =================================================================
    // registered state
    seq_state_t state;                            // sequencer state
    logic [7:0] acc;                              // accumulator
    flags_t flags;                                // status flags
    logic mem_we;                                 // write back strobe
    logic [7:0] mem_wdata;                        // write back byte
    logic discard;                                // prefetch discard
    logic done;                                   // instruction end

    // next values
    // every next value below is computed in one of the combs
    seq_state_t next_state;
    logic [7:0] next_acc;
    flags_t next_flags;
    logic next_mem_we;
    logic [7:0] next_mem_wdata;
    logic next_discard;
    logic next_done;

    // =================================================================
    // datapath helpers
    logic take;                                   // issue accepted
    logic [7:0] m;                                // operand byte
    logic [7:0] m_inv;                            // inverted operand
    logic [7:0] rot_lc;                           // left via carry
    logic [7:0] rot_r;                            // plain right
    logic [7:0] rot_rc;                           // right via carry
    logic [8:0] sub_sum;                          // nine bit sum
    logic [4:0] sub_low;                          // low nibble sum
    logic [7:0] sub_res;                          // eight bit result
    logic sub_wrap; // signed overflow
    logic [7:0] dec_res;                          // byte minus one
    logic [7:0] inc_res;                          // byte plus one
    logic [7:0] bit_mask;                         // selected bit mask
    logic sel_bit;                                // selected bit value
    logic skip;                                   // skip condition met

    // handshake is combinational: only refused during a dummy cycle
    // a request held through the dummy cycle is simply not taken
    assign issue_ready_o = (state == st_run);
    assign take = clk_en_i && issue_valid_i && issue_ready_o;
    assign m = issue_req_i.mem_byte;
    assign m_inv = ~m;

    // =================================================================
    // rotate results, built from the operand, the through-carry forms also from the old carry
    // the bit that falls out is picked up in the execution case
    // left through carry: old carry enters bit 0
    assign rot_lc = {m[MSB_POS-1:LSB_POS], flags.carry_flag};
    // plain right: bit 0 wraps to the top
    assign rot_r = {m[LSB_POS], m[MSB_POS:LSB_POS+1]};
    // right through carry: old carry enters the top
    assign rot_rc = {flags.carry_flag, m[MSB_POS:LSB_POS+1]};

    // =================================================================
    // subtract with borrow as acc + ~m + carry
    // the carry flag acts as an inverted borrow, so carry set
    // means no borrow is taken
    assign sub_sum = {1'b0, acc} + {1'b0, m_inv}
        + {8'h00, flags.carry_flag};
    assign sub_low = {1'b0, acc[NIB_W-1:0]} + {1'b0, m_inv[NIB_W-1:0]}
        + {4'h0, flags.carry_flag};
    // the nibble sum is kept apart only to give the half carry
    assign sub_res = sub_sum[7:0];
    // overflow when both addends share a sign the result lacks
    // one sign check covers both subtract forms
    assign sub_wrap = (acc[MSB_POS] == m_inv[MSB_POS])
        && (sub_res[MSB_POS] != acc[MSB_POS]);

    // =================================================================
    // increment, decrement and bit select
    // both wrap at the byte edge; a zero result raises the skip, which for increment is the wrap
    assign dec_res = m - BYTE_STEP;
    assign inc_res = m + BYTE_STEP;
    // all eight positions are legal, so no index is refused
    assign bit_mask = BYTE_STEP << issue_req_i.bit_sel;
    assign sel_bit = |(m & bit_mask);

    // =================================================================
    // skip condition per operation
    // it looks only at the operand, never at the accumulator
    always_comb begin
        case (issue_req_i.op)
            dec_skip_zero_mem,
            dec_skip_zero_to_acc: begin
                skip = (dec_res == BYTE_ZERO);
            end
            inc_skip_zero_mem,
            inc_skip_zero_to_acc: begin
                skip = (inc_res == BYTE_ZERO);
            end
            skip_if_bit_set: begin
                skip = sel_bit;
            end
            default: begin
                // rotates, subtracts and sets never skip
                skip = 1'b0;
            end
        endcase
    end

    // =================================================================
    // execution: accumulator, flags and memory write back
    // preset only applies when no instruction is taken that cycle
    // memory forms pulse the write strobe, accumulator forms never do
    always_comb begin
        next_acc = acc;
        next_flags = flags;
        next_mem_we = 1'b0;
        next_mem_wdata = mem_wdata;
        if (take) begin
            case (issue_req_i.op)
                rotate_left_via_carry_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = rot_lc;
                    next_flags.carry_flag = m[MSB_POS];
                end
                rotate_left_via_carry_to_acc: begin
                    next_acc = rot_lc;
                    next_flags.carry_flag = m[MSB_POS];
                end
                rotate_right_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = rot_r;
                end
                rotate_right_to_acc: begin
                    next_acc = rot_r;
                end
                rotate_right_via_carry_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = rot_rc;
                    next_flags.carry_flag = m[LSB_POS];
                end
                rotate_right_via_carry_to_acc: begin
                    next_acc = rot_rc;
                    next_flags.carry_flag = m[LSB_POS];
                end
                subtract_borrow_to_acc,
                subtract_borrow_to_mem: begin
                    // both forms update the four arithmetic flags
                    if (issue_req_i.op == subtract_borrow_to_acc) begin
                        next_acc = sub_res;
                    end else begin
                        next_mem_we = 1'b1;
                        next_mem_wdata = sub_res;
                    end
                    next_flags.signed_wrap_flag = sub_wrap;
                    next_flags.zero_flag = (sub_res == BYTE_ZERO);
                    next_flags.nibble_carry_flag = sub_low[NIB_W];
                    next_flags.carry_flag = sub_sum[DATA_W];
                end
                dec_skip_zero_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = dec_res;
                end
                dec_skip_zero_to_acc: begin
                    next_acc = dec_res;
                end
                set_byte_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = BYTE_ONES;
                end
                set_bit_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = m | bit_mask;
                end
                inc_skip_zero_mem: begin
                    next_mem_we = 1'b1;
                    next_mem_wdata = inc_res;
                end
                inc_skip_zero_to_acc: begin
                    next_acc = inc_res;
                end
                default: begin
                    // bit test touches neither memory nor flags
                end
            endcase
        end else if (clk_en_i && preset_i) begin
            // load a known accumulator and flag state
            next_acc = preset_acc_i;
            next_flags = preset_flags_i;
        end
    end

    // =================================================================
    // sequencer: one cycle, or two when a skip is taken
    // the dummy cycle stands in for the discarded prefetch, so the
    // issue port is closed for exactly that one cycle
    always_comb begin
        next_state = state;
        next_discard = 1'b0;
        next_done = 1'b0;
        case (state)
            st_run: begin
                if (take && skip) begin
                    next_state = st_dummy;
                    next_discard = 1'b1;
                end else if (take) begin
                    next_done = 1'b1;
                end
            end
            st_dummy: begin
                // the issue port stays closed for this one cycle
                if (clk_en_i) begin
                    next_state = st_run;
                    next_done = 1'b1;
                end else begin
                    // hold the discard while frozen
                    next_discard = discard;
                end
            end
            default: begin
                next_state = st_run;
            end
        endcase
    end

    // =================================================================
    // state registers, frozen while the enable is low
    // reset wins over a low enable so the core always recovers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= st_run;
            acc <= ACC_RESET;
            flags <= FLAGS_RESET;
            mem_we <= 1'b0;
            mem_wdata <= BYTE_ZERO;
            discard <= 1'b0;
            done <= 1'b0;
        end else if (clk_en_i) begin
            state <= next_state;
            acc <= next_acc;
            flags <= next_flags;
            mem_we <= next_mem_we;
            mem_wdata <= next_mem_wdata;
            discard <= next_discard;
            done <= next_done;
        end
    end

    // =================================================================
    // outputs straight from flops
    // no logic after the flops keeps the pin timing clean
    assign mem_we_o = mem_we;
    assign mem_wdata_o = mem_wdata;
    assign acc_o = acc;
    assign flags_o = flags;
    assign discard_o = discard;
    assign done_o = done;

endmodule

/* File: verilog/rsse_pkg.sv */
// =====================================================================
// shared types and constants for the rotate, subtract and skip slice
package rsse_pkg;

    // =================================================================
    // widths and positions
    localparam int DATA_W = 8;                    // data byte width
    localparam int SEL_W = 3;                     // bit select width
    localparam int MSB_POS = 7;                   // top bit of a byte
    localparam int LSB_POS = 0;                   // bottom bit of a byte
    localparam int NIB_W = 4;                     // low nibble width

    // =================================================================
    // fixed byte values
    localparam logic [7:0] BYTE_ONES = 8'hFF;     // whole-byte set value
    localparam logic [7:0] BYTE_ZERO = 8'h00;     // zero compare value
    localparam logic [7:0] BYTE_STEP = 8'h01;     // increment step
    localparam logic [7:0] ACC_RESET = 8'h00;     // accumulator at reset

    // =================================================================
    // cycle costs of one instruction
    localparam int PLAIN_CYCLES = 1;              // no skip taken
    localparam int SKIP_CYCLES = 2;               // skip adds a dummy

    // =================================================================
    // operations this slice executes
    typedef enum logic [3:0] {
        rotate_left_via_carry_mem,
        rotate_left_via_carry_to_acc,
        rotate_right_mem,
        rotate_right_to_acc,
        rotate_right_via_carry_mem,
        rotate_right_via_carry_to_acc,
        subtract_borrow_to_acc,
        subtract_borrow_to_mem,
        dec_skip_zero_mem,
        dec_skip_zero_to_acc,
        set_byte_mem,
        set_bit_mem,
        inc_skip_zero_mem,
        inc_skip_zero_to_acc,
        skip_if_bit_set
    } op_t;

    // status flags kept by the slice
    typedef struct packed {
        logic signed_wrap_flag;                   // signed overflow
        logic zero_flag;                          // result was zero
        logic nibble_carry_flag;                  // carry out of bit 3
        logic carry_flag;                         // carry out of bit 7
    } flags_t;

    localparam flags_t FLAGS_RESET = '0;          // all flags clear

    // one instruction handed to the slice
    typedef struct packed {
        op_t op;                                  // operation
        logic [2:0] bit_sel;                      // bit index for bit ops
        logic [7:0] mem_byte;                     // data memory operand
    } req_t;

endpackage
